// File: rtl/ghbp_pkg.sv
// Shared constants and types of the graphics host bus port.
// Assumes a single 20 MHz core clock; all host pins arrive asynchronously.
package ghbp_pkg;

  // ----------------------------------------
  // Widths and depths
  // ----------------------------------------
  localparam int DATA_W      = 16;
  localparam int BYTE_W      = 8;
  localparam int QUEUE_DEPTH = 16;
  localparam int ACT_W       = 4;
  localparam int IRQ_W       = 4;
  localparam int PIN_W       = 25;

  // ----------------------------------------
  // Clock
  // ----------------------------------------
  localparam int CORE_CLK_MAX_HZ    = 20_000_000;
  localparam int CORE_CLK_PERIOD_NS = 50;

  // ----------------------------------------
  // Host port selection
  // ----------------------------------------
  typedef enum logic [1:0] {
    GHBP_PORT_STATUS   = 2'b00,
    GHBP_PORT_BLOCK    = 2'b01,
    GHBP_PORT_REG_PTR  = 2'b10,
    GHBP_PORT_REG_DATA = 2'b11
  } ghbp_port_type;

  // ----------------------------------------
  // Synchronised pin vector layout
  // ----------------------------------------
  localparam int PIN_DATA_LSB   = 0;
  localparam int PIN_SEL_LSB    = 16;
  localparam int PIN_CS_N       = 18;
  localparam int PIN_RD_N       = 19;
  localparam int PIN_WR_N       = 20;
  localparam int PIN_ACK_N      = 21;
  localparam int PIN_INSTR_LINE = 22;
  localparam int PIN_BLOCK_LINE = 23;
  localparam int PIN_MATCH_IN   = 24;
  localparam logic [PIN_W-1:0] PIN_SYNC_RST = 25'h03C_0000;

  // ----------------------------------------
  // Status word layout
  // ----------------------------------------
  localparam int ST_ACT_LSB     = 0;
  localparam int ST_IRQ_LSB     = 4;
  localparam int ST_INSTR_SPACE = 8;
  localparam int ST_BIN_SPACE   = 9;
  localparam int ST_BOUT_AVAIL  = 10;
  localparam int ST_INSTR_LINE  = 11;
  localparam int ST_BLOCK_LINE  = 12;
  localparam int ST_MATCH_IN    = 13;
  localparam int ST_OVERRUN     = 14;
  localparam int ST_UNDERRUN    = 15;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

endpackage

// File: rtl/ghbp_stream_if.sv
// Valid/ready word stream between the port logic and its queues.
// Assumes both ends share the core clock.
`timescale 1ns/100ps
interface ghbp_stream_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: rtl/ghbp_sync.sv
// Two-stage synchroniser for a vector of asynchronous pins.
// Assumes each bit is a level that stays stable for several core clocks.
`timescale 1ns/100ps
module ghbp_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk_in,
  input  wire logic         arst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_r <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule // ghbp_sync

// File: rtl/ghbp_fifo.sv
// Word queue with registered read data and registered flags.
// Assumes producer and consumer on the core clock.
`timescale 1ns/100ps
module ghbp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic   core_clk_in,
  input  wire logic   arst_n_in,
  ghbp_stream_if.snk  wr_side,
  ghbp_stream_if.src  rd_side
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW-1:0]    rd_ptr_nxt;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign push       = wr_side.valid && wr_side.ready;
  assign pop        = rd_side.valid && rd_side.ready;
  assign rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
  assign count_nxt  = count_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= wr_side.data;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_r      <= '0;
      rd_ptr_r      <= '0;
      count_r       <= '0;
      wr_side.ready <= 1'b1;
      rd_side.valid <= 1'b0;
      rd_side.data  <= '0;
    end else begin
      wr_ptr_r      <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_r      <= rd_ptr_nxt;
      count_r       <= count_nxt;
      wr_side.ready <= count_nxt != FULL_CNT;
      rd_side.valid <= count_nxt != '0;
      // Bypass the word being written when it becomes the head
      rd_side.data  <= (push && wr_ptr_r == rd_ptr_nxt) ? wr_side.data : mem[rd_ptr_nxt];
    end
  end
endmodule // ghbp_fifo

// File: rtl/ghbp_port.sv
// Host bus slave port: pins, queues, request lines, buffer enable.
// Assumes host pins asynchronous to core_clk_in; microengine on core_clk_in.
// Contract
// - Slave only; 16-bit data bus, optional 8-bit mode.
// - Data line 15 is the word's most significant bit.
// - Two select bits with chip select pick one of four ports.
// - Read strobe with chip select drives addressed port onto bus.
// - Write strobe with chip select captures bus into addressed port.
// - Fly-by acknowledge with read strobe pushes bus word into block input queue.
// - Fly-by acknowledge with write strobe pops block output queue onto bus.
// - During fly-by acknowledge only block queues are used; select ignored.
// - Instruction queue fed only through its port, never fly-by.
// - Block queues support both port and fly-by transfers.
// - Instruction request open drain, pulled low while not requesting.
// - Instruction request released only with room for a word.
// - Block request open drain, pulled low while not ready.
// - Block request released on input room or output word available.
// - Buffer enable for status port, other ports with activity, fly-by with activity.
// - Interrupt output high while any interrupt pending; status shows cause.
// - Everything runs from one core clock of at most 20 MHz.
// - Core clock, video clock and host transfers are mutually asynchronous.
// - Reset aborts everything and forces a defined state.
// - Match output high on colour match, low otherwise.
`timescale 1ns/100ps
module ghbp_port (
  input  wire logic                      core_clk_in,
  input  wire logic                      arst_n_in,
  input  wire logic [ghbp_pkg::DATA_W-1:0] host_data_in,
  output logic      [ghbp_pkg::DATA_W-1:0] host_data_out,
  output logic                           host_data_oe_out,
  input  wire logic [1:0]                port_select_in,
  input  wire logic                      cs_n_in,
  input  wire logic                      rd_n_in,
  input  wire logic                      wr_n_in,
  input  wire logic                      flyby_dma_ack_n_in,
  input  wire logic                      byte_mode_in,
  input  wire logic                      instr_queue_request_in,
  output logic                           instr_queue_request_out,
  output logic                           instr_queue_request_oe_out,
  input  wire logic                      block_data_request_in,
  output logic                           block_data_request_out,
  output logic                           block_data_request_oe_out,
  output logic                           ext_buffer_enable_out,
  output logic                           irq_out,
  input  wire logic [ghbp_pkg::IRQ_W-1:0]  irq_pending_in,
  input  wire logic [ghbp_pkg::ACT_W-1:0]  activity_bits_in,
  input  wire logic                      block_input_mode_in,
  input  wire logic                      block_output_mode_in,
  input  wire logic                      color_match_in,
  output logic                           match_report_out,
  input  wire logic                      match_combined_in,
  output logic                           match_combined_out,
  output logic      [ghbp_pkg::DATA_W-1:0] instr_data_out,
  output logic                           instr_valid_out,
  input  wire logic                      instr_ready_in,
  output logic      [ghbp_pkg::DATA_W-1:0] bin_data_out,
  output logic                           bin_valid_out,
  input  wire logic                      bin_ready_in,
  input  wire logic [ghbp_pkg::DATA_W-1:0] bout_data_in,
  input  wire logic                      bout_valid_in,
  output logic                           bout_ready_out,
  output logic      [ghbp_pkg::DATA_W-1:0] reg_addr_out,
  output logic      [ghbp_pkg::DATA_W-1:0] reg_wdata_out,
  output logic                           reg_wr_out,
  input  wire logic [ghbp_pkg::DATA_W-1:0] reg_rdata_in
);
  import ghbp_pkg::*;
  default clocking cb_core @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [PIN_W-1:0]  pins_s;
  logic [DATA_W-1:0] data_s;
  ghbp_port_type     sel_s;
  logic              cs_s;
  logic              rd_s;
  logic              wr_s;
  logic              ack_s;
  ghbp_sync #(.W(PIN_W), .RST_VAL(PIN_SYNC_RST)) u_pin_sync (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .d_in        ({match_combined_in, block_data_request_in, instr_queue_request_in,
                   flyby_dma_ack_n_in, wr_n_in, rd_n_in, cs_n_in, port_select_in, host_data_in}),
    .q_out       (pins_s)
  );
  assign data_s = pins_s[PIN_DATA_LSB +: DATA_W];
  assign sel_s  = ghbp_port_type'(pins_s[PIN_SEL_LSB +: 2]);
  assign cs_s   = !pins_s[PIN_CS_N];
  assign rd_s   = !pins_s[PIN_RD_N];
  assign wr_s   = !pins_s[PIN_WR_N];
  assign ack_s  = !pins_s[PIN_ACK_N];

  // ----------------------------------------
  // Queues
  // ----------------------------------------
  ghbp_stream_if #(.W(DATA_W)) instr_in_if ();
  ghbp_stream_if #(.W(DATA_W)) instr_out_if ();
  ghbp_stream_if #(.W(DATA_W)) bin_in_if ();
  ghbp_stream_if #(.W(DATA_W)) bin_out_if ();
  ghbp_stream_if #(.W(DATA_W)) bout_in_if ();
  ghbp_stream_if #(.W(DATA_W)) bout_out_if ();

  ghbp_fifo #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH)) u_instr_q (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .wr_side     (instr_in_if),
    .rd_side     (instr_out_if)
  );
  ghbp_fifo #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH)) u_bin_q (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .wr_side     (bin_in_if),
    .rd_side     (bin_out_if)
  );
  ghbp_fifo #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH)) u_bout_q (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .wr_side     (bout_in_if),
    .rd_side     (bout_out_if)
  );

  assign instr_data_out     = instr_out_if.data;
  assign instr_valid_out    = instr_out_if.valid;
  assign instr_out_if.ready = instr_ready_in;
  assign bin_data_out       = bin_out_if.data;
  assign bin_valid_out      = bin_out_if.valid;
  assign bin_out_if.ready   = bin_ready_in;
  assign bout_in_if.data    = bout_data_in;
  assign bout_in_if.valid   = bout_valid_in;
  assign bout_ready_out     = bout_in_if.ready;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic              host_rd, host_wr, rd_prev_r, wr_prev_r, rd_rise, wr_rise;
  logic              wr_hi_r, rd_hi_r, do_write, do_read, any_activity_bit, overrun_r, underrun_r;
  ghbp_port_type     tgt;
  logic [BYTE_W-1:0] wr_hold_r, rd_hold_r;
  logic [DATA_W-1:0] wr_word, rd_word, status_word;

  // Fly-by swaps strobe meaning and forces the block port; chip select is
  // assumed absent then, so acknowledge simply wins
  assign host_rd = ack_s ? wr_s : (cs_s && rd_s);
  assign host_wr = ack_s ? rd_s : (cs_s && wr_s);
  assign tgt     = ack_s ? GHBP_PORT_BLOCK : sel_s;
  assign rd_rise = host_rd && !rd_prev_r;
  assign wr_rise = host_wr && !wr_prev_r;
  assign any_activity_bit     = |activity_bits_in;

  // Byte mode: low byte first, high byte completes the word
  assign do_write = wr_rise && (!byte_mode_in || wr_hi_r);
  assign do_read  = rd_rise && (!byte_mode_in || !rd_hi_r);
  assign wr_word  = byte_mode_in ? {data_s[BYTE_W-1:0], wr_hold_r} : data_s;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
    end else begin
      rd_prev_r <= host_rd;
      wr_prev_r <= host_wr;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_hi_r   <= 1'b0;
      rd_hi_r   <= 1'b0;
      wr_hold_r <= BYTE_RST;
      rd_hold_r <= BYTE_RST;
    end else begin
      if (!byte_mode_in) begin
        wr_hi_r <= 1'b0;
        rd_hi_r <= 1'b0;
      end else begin
        if (wr_rise) begin
          wr_hi_r <= !wr_hi_r;
        end
        if (rd_rise) begin
          rd_hi_r <= !rd_hi_r;
        end
      end
      if (wr_rise && !wr_hi_r) begin
        wr_hold_r <= data_s[BYTE_W-1:0];
      end
      if (do_read) begin
        rd_hold_r <= rd_word[DATA_W-1:BYTE_W];
      end
    end
  end

  // ----------------------------------------
  // Port writes
  // ----------------------------------------
  assign instr_in_if.valid = do_write && tgt == GHBP_PORT_STATUS;
  assign instr_in_if.data  = wr_word;
  assign bin_in_if.valid   = do_write && tgt == GHBP_PORT_BLOCK;
  assign bin_in_if.data    = wr_word;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_addr_out  <= WORD_RST;
      reg_wdata_out <= WORD_RST;
      reg_wr_out    <= 1'b0;
    end else begin
      reg_wr_out <= do_write && tgt == GHBP_PORT_REG_DATA;
      if (do_write && tgt == GHBP_PORT_REG_PTR) begin
        reg_addr_out <= wr_word;
      end
      if (do_write && tgt == GHBP_PORT_REG_DATA) begin
        reg_wdata_out <= wr_word;
      end
    end
  end

  // ----------------------------------------
  // Port reads
  // ----------------------------------------
  assign bout_out_if.ready = do_read && tgt == GHBP_PORT_BLOCK;

  always_comb begin
    status_word                             = WORD_RST;
    status_word[ST_ACT_LSB +: ACT_W]        = activity_bits_in;
    status_word[ST_IRQ_LSB +: IRQ_W]        = irq_pending_in;
    status_word[ST_INSTR_SPACE]             = instr_in_if.ready;
    status_word[ST_BIN_SPACE]               = bin_in_if.ready;
    status_word[ST_BOUT_AVAIL]              = bout_out_if.valid;
    status_word[ST_INSTR_LINE]              = pins_s[PIN_INSTR_LINE];
    status_word[ST_BLOCK_LINE]              = pins_s[PIN_BLOCK_LINE];
    status_word[ST_MATCH_IN]                = pins_s[PIN_MATCH_IN];
    status_word[ST_OVERRUN]                 = overrun_r;
    status_word[ST_UNDERRUN]                = underrun_r;
  end

  always_comb begin
    unique case (tgt)
      GHBP_PORT_STATUS:   rd_word = status_word;
      GHBP_PORT_BLOCK:    rd_word = bout_out_if.valid ? bout_out_if.data : WORD_RST;
      GHBP_PORT_REG_PTR:  rd_word = reg_addr_out;
      GHBP_PORT_REG_DATA: rd_word = reg_rdata_in;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      host_data_out    <= WORD_RST;
      host_data_oe_out <= 1'b0;
    end else begin
      host_data_oe_out <= host_rd;
      if (do_read) begin
        host_data_out <= byte_mode_in ? {BYTE_RST, rd_word[BYTE_W-1:0]} : rd_word;
      end else if (rd_rise) begin
        host_data_out <= {BYTE_RST, rd_hold_r};
      end
    end
  end

  // Sticky error flags; a new event wins over the clear by a status read
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      overrun_r  <= 1'b0;
      underrun_r <= 1'b0;
    end else begin
      if ((instr_in_if.valid && !instr_in_if.ready) || (bin_in_if.valid && !bin_in_if.ready)) begin
        overrun_r <= 1'b1;
      end else if (do_read && tgt == GHBP_PORT_STATUS) begin
        overrun_r <= 1'b0;
      end
      if (bout_out_if.ready && !bout_out_if.valid) begin
        underrun_r <= 1'b1;
      end else if (do_read && tgt == GHBP_PORT_STATUS) begin
        underrun_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Request lines, buffer enable, interrupt, match
  // ----------------------------------------
  logic block_release;

  // Hold low through a cycle whose push or pop may fill or drain the queue
  assign block_release = (block_input_mode_in && bin_in_if.ready && !bin_in_if.valid) ||
                         (block_output_mode_in && bout_out_if.valid && !bout_out_if.ready);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      instr_queue_request_out    <= 1'b0;
      instr_queue_request_oe_out <= 1'b1;
      block_data_request_out     <= 1'b0;
      block_data_request_oe_out  <= 1'b1;
    end else begin
      instr_queue_request_out    <= 1'b0;
      instr_queue_request_oe_out <= !instr_in_if.ready || instr_in_if.valid;
      block_data_request_out     <= 1'b0;
      block_data_request_oe_out  <= !block_release;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ext_buffer_enable_out <= 1'b0;
      irq_out               <= 1'b0;
      match_report_out      <= 1'b0;
      match_combined_out    <= 1'b0;
    end else begin
      ext_buffer_enable_out <= (cs_s && !ack_s && (sel_s == GHBP_PORT_STATUS || any_activity_bit)) ||
                               (ack_s && any_activity_bit);
      irq_out               <= |irq_pending_in;
      match_report_out      <= color_match_in;
      match_combined_out    <= pins_s[PIN_MATCH_IN];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_read_drives;
    host_rd |=> host_data_oe_out;
  endproperty
  a_read_drives: assert property (p_read_drives) else $error("bus not driven on read");
  property p_one_access;
    wr_rise |=> !wr_rise ##1 !wr_rise;
  endproperty
  a_one_access: assert property (p_one_access) else $error("repeated access per strobe");
  property p_flyby_push;
    (ack_s && rd_rise == 1'b0 && wr_rise && !byte_mode_in) |-> bin_in_if.valid && !instr_in_if.valid;
  endproperty
  a_flyby_push: assert property (p_flyby_push) else $error("fly-by write missed block input");
  property p_flyby_pop;
    (ack_s && rd_rise && !byte_mode_in && bout_out_if.valid) |-> bout_out_if.ready;
  endproperty
  a_flyby_pop: assert property (p_flyby_pop) else $error("fly-by read missed block output");
  property p_instr_req;
    !instr_queue_request_oe_out |-> instr_in_if.ready;
  endproperty
  a_instr_req: assert property (p_instr_req) else $error("instruction request without room");
  property p_block_req;
    (block_input_mode_in && !block_output_mode_in && !bin_in_if.ready) |=> block_data_request_oe_out;
  endproperty
  a_block_req: assert property (p_block_req) else $error("block request released when full");
  property p_ebe;
    (ack_s && !any_activity_bit) ##1 (ack_s && !any_activity_bit) |-> !ext_buffer_enable_out;
  endproperty
  a_ebe: assert property (p_ebe) else $error("buffer enable without activity");
  property p_irq;
    irq_out == $past(|irq_pending_in);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output wrong");
  property p_match;
    $rose(color_match_in) |=> match_report_out;
  endproperty
  a_match: assert property (p_match) else $error("match not reported");
  property p_ptr_msb;
    (do_write && tgt == GHBP_PORT_REG_PTR && !byte_mode_in) |=> reg_addr_out[15] == $past(data_s[15]);
  endproperty
  a_ptr_msb: assert property (p_ptr_msb) else $error("pointer msb misplaced");

endmodule // ghbp_port

// File: bench/ghbp_host_model.sv
// Host processor and fly-by DMA master on the system bus.
// Assumes the port samples these pins with the core clock.
`timescale 1ns/100ps
module ghbp_host_model (
  input  wire logic        core_clk_in,
  input  wire logic [15:0] bus_in,
  output logic      [15:0] drv_out,
  output logic      [1:0]  sel_out,
  output logic             cs_n_out,
  output logic             rd_n_out,
  output logic             wr_n_out,
  output logic             ack_n_out
);
  initial begin
    {cs_n_out, rd_n_out, wr_n_out, ack_n_out} = 4'hF;
    sel_out = 2'h0;
    drv_out = 16'h0000;
  end
  // One strobe per access, held and idled long enough; never cs with ack
  task automatic acc(input logic wr, input logic fly, input logic [1:0] sel,
                     input logic [15:0] d, output logic [15:0] q);
    @(negedge core_clk_in);
    sel_out = sel;
    drv_out = d;
    cs_n_out = fly;
    ack_n_out = !fly;
    wr_n_out = !wr;
    rd_n_out = wr;
    repeat (5) @(negedge core_clk_in);
    q = bus_in;
    {cs_n_out, rd_n_out, wr_n_out, ack_n_out} = 4'hF;
    // Released lines show the inverse, not a stale copy
    drv_out = ~d;
    sel_out = ~sel;
    repeat (4) @(negedge core_clk_in);
  endtask
endmodule // ghbp_host_model

// File: bench/tb_ghbp_port.sv
// Self-checking bench of the host bus port.
// Assumes ghbp_pkg and the port's modules are compiled first.
`timescale 1ns/100ps
module tb_ghbp_port;
  import ghbp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, iq_oe, bq_oe, d_oe, ebe, irq, mrep, mcomb, ivld, bvld, bordy, rwr;
  logic [15:0] hd, drv, q, idat, bdat, raddr, wdat, bout_d = 16'h5AA5;
  logic [1:0] sel;
  logic cs_n, rd_n, wr_n, ack_n, bin_mode = 1'b0, bin_rdy = 1'b0, bout_v = 1'b0, cmatch = 1'b0, bmode = 1'b0;
  logic [3:0] irqp = 4'h0, act = 4'h0;
  int err_total = 0, n_compared = 0, cyc = 0, n_regwr = 0;
  initial forever #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (rwr === 1'b1) n_regwr <= n_regwr + 1;
  // Undriven bus reads back as the inverse of the host's last drive
  always @(posedge clk) if (cyc == 20000) begin err_total++; results(); end
  ghbp_host_model host (.core_clk_in(clk), .bus_in(d_oe ? hd : ~drv), .drv_out(drv), .sel_out(sel),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .ack_n_out(ack_n));
  // Open-drain lines with pull-up; match output looped back
  ghbp_port dut (.core_clk_in(clk), .arst_n_in(rst_n), .host_data_in(d_oe ? hd : drv),
    .host_data_out(hd), .host_data_oe_out(d_oe), .port_select_in(sel), .cs_n_in(cs_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .flyby_dma_ack_n_in(ack_n), .byte_mode_in(bmode),
    .instr_queue_request_in(!iq_oe), .instr_queue_request_out(), .instr_queue_request_oe_out(iq_oe),
    .block_data_request_in(!bq_oe), .block_data_request_out(), .block_data_request_oe_out(bq_oe),
    .ext_buffer_enable_out(ebe), .irq_out(irq), .irq_pending_in(irqp), .activity_bits_in(act),
    .block_input_mode_in(bin_mode), .block_output_mode_in(1'b0), .color_match_in(cmatch),
    .match_report_out(mrep), .match_combined_in(mrep), .match_combined_out(mcomb),
    .instr_data_out(idat), .instr_valid_out(ivld), .instr_ready_in(1'b0), .bin_data_out(bdat),
    .bin_valid_out(bvld), .bin_ready_in(bin_rdy), .bout_data_in(bout_d), .bout_valid_in(bout_v),
    .bout_ready_out(bordy), .reg_addr_out(raddr), .reg_wdata_out(wdat), .reg_wr_out(rwr),
    .reg_rdata_in(16'hC33C));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin err_total++; $display("BAD %0t seen %h expected %h", $time, seen, exp); end
  endtask
  task automatic t_reset;
    chk({d_oe, ebe, irq, bordy, iq_oe}, 16'h0002);
    $display("test reset done");
  endtask
  task automatic t_ports;
    host.acc(1'b1, 1'b0, 2'h0, 16'h8001, q);
    chk({15'h0, ivld}, 16'h0001);
    chk(idat, 16'h8001);
    host.acc(1'b1, 1'b0, 2'h2, 16'h1234, q);
    host.acc(1'b1, 1'b0, 2'h3, 16'hA5C3, q);
    chk(raddr, 16'h1234);
    chk(wdat, 16'hA5C3);
    chk(n_regwr[15:0], 16'h0001);
    host.acc(1'b0, 1'b0, 2'h2, 16'h0000, q);
    chk(q, 16'h1234);
    host.acc(1'b0, 1'b0, 2'h3, 16'h0000, q);
    chk(q, 16'hC33C);
    $display("test ports done");
  endtask
  task automatic t_flyby;
    host.acc(1'b0, 1'b1, 2'h2, 16'h0F0E, q);
    chk(bdat, 16'h0F0E);
    chk(raddr, 16'h1234);
    @(negedge clk) bout_v = 1'b1;
    @(negedge clk) bout_v = 1'b0;
    host.acc(1'b1, 1'b1, 2'h3, 16'h0000, q);
    chk(q, 16'h5AA5);
    bin_rdy = 1'b1;
    repeat (3) @(negedge clk);
    bin_rdy = 1'b0;
    $display("test flyby done");
  endtask
  task automatic t_full;
    bin_mode = 1'b1;
    repeat (3) @(negedge clk);
    chk({15'h0, bq_oe}, 16'h0000);
    for (int i = 0; i < 16; i++) host.acc(1'b1, 1'b0, 2'h1, 16'h0100 + i[15:0], q);
    chk({15'h0, bq_oe}, 16'h0001);
    bin_rdy = 1'b1;
    repeat (20) @(negedge clk);
    chk({15'h0, bvld}, 16'h0000);
    irqp = 4'h2;
    cmatch = 1'b1;
    repeat (5) @(negedge clk);
    chk({14'h0, irq, mcomb}, 16'h0003);
    irqp = 4'h0;
    repeat (2) @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    $display("test full done");
  endtask
  task automatic t_instr;
    for (int i = 0; i < 16; i++) host.acc(1'b1, 1'b0, 2'h0, 16'h0200 + i[15:0], q);
    chk({15'h0, iq_oe}, 16'h0001);
    host.acc(1'b0, 1'b0, 2'h1, 16'h0000, q);
    chk(q, 16'h0000);
    host.acc(1'b0, 1'b0, 2'h0, 16'h0000, q);
    chk(q, 16'hF200);
    host.acc(1'b0, 1'b0, 2'h0, 16'h0000, q);
    chk(q, 16'h3200);
    $display("test instr done");
  endtask
  task automatic t_byte;
    bmode = 1'b1;
    host.acc(1'b1, 1'b0, 2'h2, 16'hFF56, q);
    host.acc(1'b1, 1'b0, 2'h2, 16'hFF78, q);
    chk(raddr, 16'h7856);
    host.acc(1'b0, 1'b0, 2'h2, 16'h0000, q);
    chk(q, 16'h0056);
    host.acc(1'b0, 1'b0, 2'h2, 16'h0000, q);
    chk(q, 16'h0078);
    bmode = 1'b0;
    $display("test byte done");
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_ports();
    t_flyby();
    t_full();
    t_instr();
    t_byte();
    results();
  end
endmodule // tb_ghbp_port
